// ---- hdl/relay_regs_pkg.sv ----
// Constants for the relay driver serial register bank.
// Assumes one system clock; serial pins arrive already synchronous to it.
package relay_regs_pkg;

  // Access word layout
  localparam int          WORD_BITS      = 16;
  localparam int          RW_BIT         = 15;
  localparam int          RW_INV_BIT     = 14;
  localparam int          PRIM_HI        = 13;
  localparam int          PRIM_LO        = 10;
  localparam int          SEC_HI         = 9;
  localparam int          SEC_LO         = 8;
  localparam int          DATA_HI        = 7;
  localparam int          WIDE_DATA_HI   = 9;
  localparam int          DAISY_STEP     = 8;
  localparam logic [7:0]  CNT_MAX        = 8'hFF;

  // Primary and secondary addresses
  localparam logic [3:0]  PRIM_OUT_GRP   = 4'h0;
  localparam logic [3:0]  PRIM_MAP_GRP   = 4'h1;
  localparam logic [3:0]  PRIM_DIAG_GRP  = 4'h2;
  localparam logic [3:0]  PRIM_HW_GRP    = 4'h3;
  localparam logic [3:0]  PRIM_PGEN0     = 4'h4;
  localparam logic [3:0]  PRIM_PGEN1     = 4'h5;
  localparam logic [1:0]  SEC_0          = 2'h0;
  localparam logic [1:0]  SEC_1          = 2'h1;
  localparam logic [1:0]  SEC_2          = 2'h2;
  localparam logic [1:0]  SEC_3          = 2'h3;

  // Reset values
  localparam logic [7:0]  RST_OUT        = 8'h00;
  localparam logic [7:0]  RST_INRUSH     = 8'h00;
  localparam logic [7:0]  RST_MAP0       = 8'h04;
  localparam logic [7:0]  RST_MAP1       = 8'h08;
  localparam logic [7:0]  RST_IOL        = 8'h00;
  localparam logic [3:0]  RST_OLON_SEL   = 4'hF;
  localparam logic [3:0]  RST_PAIRING    = 4'h0;
  localparam logic [0:0]  RST_ACTIVE     = 1'h0;
  localparam logic [9:0]  RST_PGEN       = 10'h000;

  // Field positions
  localparam int          HW_ACT_BIT     = 7;
  localparam int          HW_RST_BIT     = 6;
  localparam int          HW_PAR_HI      = 3;
  localparam int          OLON_SEL_HI    = 3;
  localparam int          INPUT_STATUS_MONITOR_TER_BIT   = 7;
  localparam int          DIAG_TER_BIT   = 10;
  localparam logic [3:0]  OLON_OFF_CODE  = 4'hF;

  // Channels usable as high-side switches for the on-state check
  localparam logic [7:0]  HIGH_SIDE_MASK = 8'hFF;

  // Kind of answer queued for the next frame
  typedef enum logic [1:0] {
    RESP_DIAG = 2'b00,
    RESP_REG  = 2'b01,
    RESP_WIDE = 2'b10
  } resp_kind_e;

endpackage : relay_regs_pkg

// ---- hdl/reg_field.sv ----
// One writable register field with its own reset value.
// Assumes the caller forms the clear and write strobes on clk_sys.
module reg_field #(
  parameter int             W   = 8,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and clear
  input  wire logic         clk_sys,
  input  wire logic         clear,
  // Write port
  input  wire logic         we,
  input  wire logic [W-1:0] d,
  // Stored value
  output logic      [W-1:0] q
);

  // Clear has priority so a reset command wins over a same-cycle write
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      q <= RST;
    end else if (we) begin
      q <= d;
    end
  end

endmodule // reg_field

// ---- hdl/relay_driver_spi_register_map.sv ----
// Register bank behind the 16-bit serial control port of the relay driver.
// Assumes sclk, csn and mosi are synchronous to clk_sys and much slower than it.
//
// What this block does
// - Word: bit15 write, bit14 its inverse, primary 13:10, secondary 9:8, data 7:0.
// - Pulse generator registers take ten data bits 9:0 under primary address only.
// - Output control: one bit per channel, 1 switches on, resets to 0.
// - Inrush mode: 0 latches off on error, 1 restarts automatically.
// - Input pin 0 mapping ties channels to pin 0; resets with channel 2 set.
// - Input pin 1 mapping ties channels to pin 1; resets with channel 3 set.
// - Input status monitor is read-only and carries the previous frame error flag.
// - Open-load current register enables diagnostic current per channel, resets to 0.
// - Output status monitor is read-only, 1 where comparator shows open-load level.
// - On-state open-load monitor is read-only, valid for high-side channels only.
// - Channel select code 0 to 7 picks checked channel; 15 default disables.
// - Hardware configuration bit 7 requests active mode; 0 leaves it.
// - Writing bit 6 executes a reset command; bit clears itself.
// - Bits 3:0 pair neighbouring channels' protection; bits 5:4 reserved, read 0.
// - Latch clear is write-only; 1 clears that channel's error latch.
// - Error flag set unless frame had 16 plus multiple of 8 clocks, 248 at most.
// - First pulse generator: bits 9:8 divider, bits 7:0 duty cycle.
module relay_driver_spi_register_map (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Serial control port
  input  wire logic       sclk,
  input  wire logic       csn,
  input  wire logic       mosi,
  output logic            misoOut,
  output logic            misoEn,
  // Parallel input pins
  input  wire logic [1:0] inputPins,
  // Analog diagnosis results
  input  wire logic [7:0] outputStatus,
  input  wire logic [7:0] onOpenLoad,
  // Channel control towards the power stage
  output logic [7:0]      channelOn,
  output logic [7:0]      inrushRestart,
  output logic [7:0]      openloadCurrentEnable,
  output logic [3:0]      checkedChannelSelect,
  output logic [7:0]      errorLatchClear,
  // Device configuration
  output logic            activeModeRequest,
  output logic [3:0]      channelPairing,
  output logic            resetCommand,
  output logic [9:0]      pulseGen0Config,
  output logic [9:0]      pulseGen1Config
);
  import relay_regs_pkg::*;

  // Serial engine state
  logic [15:0]      shift_r;
  logic [7:0]       bitCnt_r;
  logic             sclkPrev_r;
  logic             csnPrev_r;
  logic             misoOut_r;
  logic             misoEn_r;

  // Answer queued for the next frame
  resp_kind_e       respKind_r;
  logic [3:0]       respPrim_r;
  logic [1:0]       respSec_r;
  logic             terFlag_r;

  // Outputs held in flops
  logic [7:0]       channelOn_r;
  logic [7:0]       latchClear_r;
  logic             softReset_r;

  // Register contents
  logic [7:0]       outCtrl;
  logic [7:0]       inrushCtrl;
  logic [7:0]       map0;
  logic [7:0]       map1;
  logic [7:0]       iolEnable;
  logic [3:0]       olonSel;
  logic [3:0]       pairing;
  logic [0:0]       activeMode;
  logic [9:0]       pgen0;
  logic [9:0]       pgen1;

  // Edge and frame events
  wire              sclkRise   = ~csn & sclk & ~sclkPrev_r;
  wire              sclkFall   = ~csn & ~sclk & sclkPrev_r;
  wire              frameStart = csnPrev_r & ~csn;
  wire              frameEnd   = ~csnPrev_r & csn;

  // Clock count check for plain and daisy-chained frames
  wire              countOk    = (bitCnt_r >= 8'(WORD_BITS)) &&
                                 (bitCnt_r[2:0] == 3'h0) &&
                                 (bitCnt_r != CNT_MAX);

  // Command word fields of the last sixteen bits clocked in
  wire              cmdWrite   = shift_r[RW_BIT] & ~shift_r[RW_INV_BIT];
  wire              cmdRead    = ~shift_r[RW_BIT] & shift_r[RW_INV_BIT];
  wire [3:0]        cmdPrim    = shift_r[PRIM_HI:PRIM_LO];
  wire [1:0]        cmdSec     = shift_r[SEC_HI:SEC_LO];
  wire [7:0]        cmdData    = shift_r[DATA_HI:0];
  wire [9:0]        cmdWide    = shift_r[WIDE_DATA_HI:0];
  wire              cmdIsWide  = (cmdPrim == PRIM_PGEN0) || (cmdPrim == PRIM_PGEN1);

  // A malformed frame is dropped whole, so a bad count never writes
  wire              wrOk       = frameEnd & countOk & cmdWrite;
  wire              rdOk       = frameEnd & countOk & cmdRead;

  // Register write strobes
  wire              weOut      = wrOk && cmdPrim == PRIM_OUT_GRP  && cmdSec == SEC_0;
  wire              weInrush   = wrOk && cmdPrim == PRIM_OUT_GRP  && cmdSec == SEC_1;
  wire              weMap0     = wrOk && cmdPrim == PRIM_MAP_GRP  && cmdSec == SEC_0;
  wire              weMap1     = wrOk && cmdPrim == PRIM_MAP_GRP  && cmdSec == SEC_1;
  wire              weIol      = wrOk && cmdPrim == PRIM_DIAG_GRP && cmdSec == SEC_0;
  wire              weOlonAddr = wrOk && cmdPrim == PRIM_DIAG_GRP && cmdSec == SEC_3;
  wire              weHw       = wrOk && cmdPrim == PRIM_HW_GRP   && cmdSec == SEC_0;
  wire              weClear    = wrOk && cmdPrim == PRIM_HW_GRP   && cmdSec == SEC_1;
  wire              wePgen0    = wrOk && cmdPrim == PRIM_PGEN0;
  wire              wePgen1    = wrOk && cmdPrim == PRIM_PGEN1;

  // Reserved selector codes are dropped; the previous choice stays in force
  wire              selCodeOk  = ~cmdData[OLON_SEL_HI] ||
                                 (cmdData[OLON_SEL_HI:0] == OLON_OFF_CODE);
  wire              weOlon     = weOlonAddr & selCodeOk;

  // Reset command request from the configuration write
  wire              softRstReq = weHw & cmdData[HW_RST_BIT];

  // Either reset returns every register to its default
  wire              regClear   = reset | softReset_r;

  // Plain byte registers
  reg_field #(.W(8), .RST(RST_OUT)) u_outCtrl (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weOut),
    .d       (cmdData),
    .q       (outCtrl)
  );

  reg_field #(.W(8), .RST(RST_INRUSH)) u_inrush (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weInrush),
    .d       (cmdData),
    .q       (inrushCtrl)
  );

  reg_field #(.W(8), .RST(RST_MAP0)) u_map0 (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weMap0),
    .d       (cmdData),
    .q       (map0)
  );

  reg_field #(.W(8), .RST(RST_MAP1)) u_map1 (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weMap1),
    .d       (cmdData),
    .q       (map1)
  );

  reg_field #(.W(8), .RST(RST_IOL)) u_iol (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weIol),
    .d       (cmdData),
    .q       (iolEnable)
  );

  // Only the low nibble of the selector is stored; bits 7:4 are reserved
  reg_field #(.W(4), .RST(RST_OLON_SEL)) u_olonSel (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weOlon),
    .d       (cmdData[OLON_SEL_HI:0]),
    .q       (olonSel)
  );

  // Configuration fields; bits 5:4 and the reset bit are never stored
  reg_field #(.W(4), .RST(RST_PAIRING)) u_pairing (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weHw),
    .d       (cmdData[HW_PAR_HI:0]),
    .q       (pairing)
  );

  reg_field #(.W(1), .RST(RST_ACTIVE)) u_active (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (weHw),
    .d       (cmdData[HW_ACT_BIT]),
    .q       (activeMode)
  );

  // Ten-bit pulse generator settings
  reg_field #(.W(10), .RST(RST_PGEN)) u_pgen0 (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (wePgen0),
    .d       (cmdWide),
    .q       (pgen0)
  );

  reg_field #(.W(10), .RST(RST_PGEN)) u_pgen1 (
    .clk_sys (clk_sys),
    .clear   (regClear),
    .we      (wePgen1),
    .d       (cmdWide),
    .q       (pgen1)
  );

  // Read-back values, formed when the answer is loaded
  wire [7:0]        instValue  = {terFlag_r, 5'h00, inputPins};
  wire [7:0]        olonValue  = onOpenLoad & HIGH_SIDE_MASK;
  wire [7:0]        hwValue    = {activeMode, 3'h0, pairing};
  wire [7:0]        selValue   = {4'h0, olonSel};

  // Byte read multiplexer; write-only and unmapped addresses read zero
  logic [7:0]       readByte;
  always_comb begin
    readByte = 8'h00;
    unique case ({respPrim_r, respSec_r})
      {PRIM_OUT_GRP,  SEC_0}: readByte = outCtrl;
      {PRIM_OUT_GRP,  SEC_1}: readByte = inrushCtrl;
      {PRIM_MAP_GRP,  SEC_0}: readByte = map0;
      {PRIM_MAP_GRP,  SEC_1}: readByte = map1;
      {PRIM_MAP_GRP,  SEC_2}: readByte = instValue;
      {PRIM_DIAG_GRP, SEC_0}: readByte = iolEnable;
      {PRIM_DIAG_GRP, SEC_1}: readByte = outputStatus;
      {PRIM_DIAG_GRP, SEC_2}: readByte = olonValue;
      {PRIM_DIAG_GRP, SEC_3}: readByte = selValue;
      {PRIM_HW_GRP,   SEC_0}: readByte = hwValue;
      default:                readByte = 8'h00;
    endcase
  end

  // Ten-bit read for the pulse generator registers
  wire [9:0]        readWide   = (respPrim_r == PRIM_PGEN1) ? pgen1 : pgen0;

  // Word shifted out in the next frame
  logic [15:0]      respWord;
  always_comb begin
    respWord = 16'h0000;
    unique case (respKind_r)
      RESP_DIAG: respWord = 16'(terFlag_r) << DIAG_TER_BIT;
      RESP_REG:  respWord = {2'b10, respPrim_r, respSec_r, readByte};
      RESP_WIDE: respWord = {2'b10, respPrim_r, readWide};
      default:   respWord = 16'h0000;
    endcase
  end

  // Channel drive merges register control with the mapped input pins
  wire [7:0]        driveNxt   = outCtrl |
                                 (map0 & {8{inputPins[0]}}) |
                                 (map1 & {8{inputPins[1]}});

  // Edge trackers for the serial pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclkPrev_r <= 1'b0;
      csnPrev_r  <= 1'b1;
    end else begin
      sclkPrev_r <= sclk;
      csnPrev_r  <= csn;
    end
  end

  // One shift register serves in and out, which gives daisy-chain pass-through
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift_r <= 16'h0000;
    end else if (frameStart) begin
      shift_r <= respWord;
    end else if (sclkRise) begin
      shift_r <= {shift_r[14:0], mosi};
    end
  end

  // Clock counter saturates so a runaway frame cannot wrap into a legal count
  always_ff @(posedge clk_sys) begin
    if (reset || frameStart) begin
      bitCnt_r <= 8'h00;
    end else if (sclkRise && bitCnt_r != CNT_MAX) begin
      bitCnt_r <= bitCnt_r + 8'h01;
    end
  end

  // Data out changes on falling clock; the first bit is ready at select
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      misoOut_r <= 1'b0;
      misoEn_r  <= 1'b0;
    end else begin
      misoEn_r <= ~csn;
      if (frameStart) begin
        misoOut_r <= respWord[WORD_BITS-1];
      end else if (sclkFall) begin
        misoOut_r <= shift_r[WORD_BITS-1];
      end
    end
  end

  // Error flag reflects each frame; any reset forces it high
  always_ff @(posedge clk_sys) begin
    if (regClear) begin
      terFlag_r <= 1'b1;
    end else if (frameEnd) begin
      terFlag_r <= ~countOk;
    end
  end

  // After any reset the first answer is the input status register
  always_ff @(posedge clk_sys) begin
    if (regClear) begin
      respKind_r <= RESP_REG;
      respPrim_r <= PRIM_MAP_GRP;
      respSec_r  <= SEC_2;
    end else if (rdOk) begin
      respKind_r <= cmdIsWide ? RESP_WIDE : RESP_REG;
      respPrim_r <= cmdPrim;
      respSec_r  <= cmdIsWide ? SEC_0 : cmdSec;
    end else if (frameEnd) begin
      respKind_r <= RESP_DIAG;
      respPrim_r <= PRIM_OUT_GRP;
      respSec_r  <= SEC_0;
    end
  end

  // Strobes: latch clear and reset command last one cycle each
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latchClear_r <= 8'h00;
      softReset_r  <= 1'b0;
    end else begin
      latchClear_r <= weClear ? cmdData : 8'h00;
      softReset_r  <= softRstReq;
    end
  end

  // Registered channel drive
  always_ff @(posedge clk_sys) begin
    if (regClear) begin
      channelOn_r <= 8'h00;
    end else begin
      channelOn_r <= driveNxt;
    end
  end

  // Output assignments
  assign misoOut               = misoOut_r;
  assign misoEn                = misoEn_r;
  assign channelOn             = channelOn_r;
  assign inrushRestart         = inrushCtrl;
  assign openloadCurrentEnable = iolEnable;
  assign checkedChannelSelect  = olonSel;
  assign errorLatchClear       = latchClear_r;
  assign activeModeRequest     = activeMode[0];
  assign channelPairing        = pairing;
  assign resetCommand          = softReset_r;
  assign pulseGen0Config       = pgen0;
  assign pulseGen1Config       = pgen1;

endmodule // relay_driver_spi_register_map

// ---- tb/relay_checker.sv ----
// Port-level assertions for the relay register bank.
// Assumes it is bound to the top module and sees only its ports.
module relay_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Serial port
  input wire logic       sclk,
  input wire logic       csn,
  input wire logic       mosi,
  input wire logic       misoOut,
  input wire logic       misoEn,
  // Pins and diagnosis
  input wire logic [1:0] inputPins,
  input wire logic [7:0] outputStatus,
  input wire logic [7:0] onOpenLoad,
  // Controls
  input wire logic [7:0] channelOn,
  input wire logic [7:0] inrushRestart,
  input wire logic [7:0] openloadCurrentEnable,
  input wire logic [3:0] checkedChannelSelect,
  input wire logic [7:0] errorLatchClear,
  input wire logic       activeModeRequest,
  input wire logic [3:0] channelPairing,
  input wire logic       resetCommand,
  input wire logic [9:0] pulseGen0Config,
  input wire logic [9:0] pulseGen1Config
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // History of chip select and reset command, so updates can be tied to a frame end
  logic [2:0] csnHist_r;
  logic [1:0] cmdHist_r;
  always_ff @(posedge clk_sys) begin
    csnHist_r <= {csnHist_r[1:0], csn};
    cmdHist_r <= {cmdHist_r[0], resetCommand};
  end
  wire logic endRecent = (csnHist_r[0] & ~csnHist_r[1]) | (csnHist_r[1] & ~csnHist_r[2]);
  wire logic cmdRecent = |cmdHist_r;

  property p_rstVals; $fell(reset) |-> checkedChannelSelect == 4'hF && channelOn == 8'h00;
  endproperty
  a_rstVals: assert property (p_rstVals) else $error("reset values wrong");
  property p_misoEn; misoEn == !$past(csn); endproperty
  a_misoEn: assert property (p_misoEn) else $error("output enable off frame");
  property p_cmdPulse; resetCommand |=> !resetCommand; endproperty
  a_cmdPulse: assert property (p_cmdPulse) else $error("reset pulse too long");
  property p_cmdEnd; resetCommand |-> endRecent; endproperty
  a_cmdEnd: assert property (p_cmdEnd) else $error("reset pulse off frame");
  property p_cmdClr;
    resetCommand |-> ##[1:2] (checkedChannelSelect == 4'hF && !activeModeRequest
                              && channelPairing == 4'h0 && inrushRestart == 8'h00);
  endproperty
  a_cmdClr: assert property (p_cmdClr) else $error("reset command kept state");
  property p_selLegal; checkedChannelSelect <= 4'h7 || checkedChannelSelect == 4'hF;
  endproperty
  a_selLegal: assert property (p_selLegal) else $error("reserved selector held");
  property p_clrPulse; |errorLatchClear |=> errorLatchClear == 8'h00 ##0 $past(endRecent);
  endproperty
  a_clrPulse: assert property (p_clrPulse) else $error("latch clear pulse bad");
  property p_inrushEnd; $changed(inrushRestart) |-> endRecent || cmdRecent; endproperty
  a_inrushEnd: assert property (p_inrushEnd) else $error("inrush changed off frame");
  property p_actEnd; $changed(activeModeRequest) |-> endRecent || cmdRecent; endproperty
  a_actEnd: assert property (p_actEnd) else $error("active mode changed off frame");
endmodule // relay_checker

// ---- tb/spi_host_model.sv ----
// Host serial master model: frames words onto the control port, mode 0.
// Assumes the bank samples sclk with clk_sys; half periods of two cycles.
module spi_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial port
  output logic     sclk,
  output logic     csn,
  output logic     mosi,
  input wire logic misoOut
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end
  // Step off the edge so pins never race the sampling clock
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One frame of n clocks, MSB first; the last 16 bits carry the word, or only its low n bits when n is under 16
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    logic [31:0] v;
    v = {16'h0000, w};
    rx = 16'h0000;
    tk(1);
    csn = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = v[n-1-i];
      tk(2);
      rx = {rx[14:0], misoOut};
      sclk = 1'b1;
      tk(2);
      sclk = 1'b0;
    end
    tk(2);
    csn = 1'b1;
    mosi = ~mosi; // Idle line flips so a stale bit is never taken as data
    tk(3);
  endtask
endmodule // spi_host_model

// ---- tb/relay_driver_spi_register_map_tb.sv ----
// Self-checking bench for the relay register bank.
// Assumes the host model and checker files are compiled before this one.
module relay_driver_spi_register_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        sclk, csn, mosi, misoOut, misoEn, activeModeRequest, resetCommand;
  logic [1:0]  inputPins = 2'b01;
  logic [7:0]  outputStatus = 8'h00;
  logic [7:0]  onOpenLoad = 8'h00;
  logic [7:0]  channelOn, inrushRestart, openloadCurrentEnable, errorLatchClear;
  logic [3:0]  checkedChannelSelect, channelPairing, sel;
  logic [9:0]  pulseGen0Config, pulseGen1Config;
  logic [15:0] rx;
  logic [7:0]  clearSeen = 8'h00;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cmdCount = 0;
  // Register places with reset values
  logic [15:0] defs [8] = '{16'h0000, 16'h0100, 16'h0404, 16'h0508,
                            16'h0800, 16'h0B0F, 16'h0C00, 16'h0D00};

  always #20 clk_sys = ~clk_sys;

  relay_driver_spi_register_map relay_driver_spi_register_map_i (
    .clk_sys(clk_sys), .reset(reset), .sclk(sclk), .csn(csn), .mosi(mosi),
    .misoOut(misoOut), .misoEn(misoEn), .inputPins(inputPins),
    .outputStatus(outputStatus), .onOpenLoad(onOpenLoad), .channelOn(channelOn),
    .inrushRestart(inrushRestart), .openloadCurrentEnable(openloadCurrentEnable),
    .checkedChannelSelect(checkedChannelSelect), .errorLatchClear(errorLatchClear),
    .activeModeRequest(activeModeRequest), .channelPairing(channelPairing),
    .resetCommand(resetCommand), .pulseGen0Config(pulseGen0Config),
    .pulseGen1Config(pulseGen1Config));
  spi_host_model spi_host_model_i (
    .clk_sys(clk_sys), .sclk(sclk), .csn(csn), .mosi(mosi), .misoOut(misoOut));

  // Catch one-cycle strobes, which a task would otherwise miss
  always @(posedge clk_sys) begin
    clearSeen <= clearSeen | errorLatchClear;
    if (resetCommand === 1'b1) cmdCount <= cmdCount + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] p, input logic [1:0] s, input logic [7:0] d);
    spi_host_model_i.xfer({2'b10, p, s, d}, 16, rx);
  endtask
  // The answer of a read arrives in the following frame
  task automatic rd(input logic [3:0] p, input logic [1:0] s, input logic [7:0] e);
    spi_host_model_i.xfer({2'b01, p, s, 8'h00}, 16, rx);
    spi_host_model_i.xfer(16'h4000, 16, rx);
    chk(rx, {2'b10, p, s, e});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    spi_host_model_i.xfer(16'h4000, 16, rx);
    chk(rx, 16'h8681);
    for (int i = 0; i < 8; i++) rd(defs[i][13:10], defs[i][9:8], defs[i][7:0]);
    $display("test defaults done");
    inputPins = 2'b00;
    for (int i = 0; i < 5; i++) begin
      wr(defs[i][13:10], defs[i][9:8], 8'hA5 ^ i[7:0]);
      rd(defs[i][13:10], defs[i][9:8], 8'hA5 ^ i[7:0]);
    end
    chk({8'h00, channelOn}, 16'h00A5);
    chk({8'h00, inrushRestart}, 16'h00A4);
    chk({8'h00, openloadCurrentEnable}, 16'h00A1);
    wr(4'h0, 2'h0, 8'h00);
    wr(4'h1, 2'h0, 8'h11);
    wr(4'h1, 2'h1, 8'h22);
    for (int p = 1; p < 4; p++) begin
      inputPins = p[1:0];
      repeat (3) @(posedge clk_sys);
      #1;
      chk({8'h00, channelOn}, {8'h00, (p[0] ? 8'h11 : 8'h00) | (p[1] ? 8'h22 : 8'h00)});
    end
    $display("test readback done");
    outputStatus = 8'h3C;
    onOpenLoad = 8'hC3;
    inputPins = 2'b10;
    wr(4'h2, 2'h1, 8'hFF);
    rd(4'h2, 2'h1, 8'h3C);
    rd(4'h2, 2'h2, 8'hC3);
    rd(4'h1, 2'h2, 8'h02);
    for (int c = 0; c < 16; c++) begin
      wr(4'h2, 2'h3, {4'hF, c[3:0]});
      sel = (c < 8 || c == 15) ? c[3:0] : 4'h7;
      rd(4'h2, 2'h3, {4'h0, sel});
      chk({12'h000, checkedChannelSelect}, {12'h000, sel});
    end
    $display("test monitors done");
    wr(4'h3, 2'h0, 8'hBF);
    rd(4'h3, 2'h0, 8'h8F);
    chk({11'h000, activeModeRequest, channelPairing}, 16'h001F);
    wr(4'h3, 2'h0, 8'h40);
    rd(4'h0, 2'h0, 8'h00);
    rd(4'h1, 2'h0, 8'h04);
    rd(4'h3, 2'h0, 8'h00);
    chk(16'(cmdCount), 16'h0001);
    clearSeen = 8'h00;
    wr(4'h3, 2'h1, 8'h5A);
    chk({8'h00, clearSeen}, 16'h005A);
    rd(4'h3, 2'h1, 8'h00);
    $display("test config done");
    spi_host_model_i.xfer({2'b10, 4'h4, 10'h2A5}, 16, rx);
    spi_host_model_i.xfer({2'b10, 4'h5, 10'h15A}, 16, rx);
    chk({6'h00, pulseGen0Config}, 16'h02A5);
    chk({6'h00, pulseGen1Config}, 16'h015A);
    spi_host_model_i.xfer({2'b01, 4'h4, 10'h000}, 16, rx);
    spi_host_model_i.xfer(16'h4000, 16, rx);
    chk(rx, {2'b10, 4'h4, 10'h2A5});
    inputPins = 2'b00;
    spi_host_model_i.xfer(16'h80FF, 15, rx);
    spi_host_model_i.xfer(16'hC0FF, 16, rx);
    chk(rx, 16'h0400);
    chk({8'h00, channelOn}, 16'h0000);
    spi_host_model_i.xfer(16'h8033, 24, rx);
    chk({8'h00, channelOn}, 16'h0033);
    $display("test framing done");
    summarize();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
endmodule // relay_driver_spi_register_map_tb

bind relay_driver_spi_register_map relay_checker relay_checker_i (
  .clk_sys(clk_sys), .reset(reset), .sclk(sclk), .csn(csn), .mosi(mosi),
  .misoOut(misoOut), .misoEn(misoEn), .inputPins(inputPins),
  .outputStatus(outputStatus), .onOpenLoad(onOpenLoad), .channelOn(channelOn),
  .inrushRestart(inrushRestart), .openloadCurrentEnable(openloadCurrentEnable),
  .checkedChannelSelect(checkedChannelSelect), .errorLatchClear(errorLatchClear),
  .activeModeRequest(activeModeRequest), .channelPairing(channelPairing),
  .resetCommand(resetCommand), .pulseGen0Config(pulseGen0Config),
  .pulseGen1Config(pulseGen1Config));
